// File: src/stdi_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts for the
//          S/T digital system interface block.
// Assumes: AXI4-Lite register word per offset, 250 MHz system clock.
// Notes:   Included by its bare name; definitions only.
// Functional notes
// - Slave modes: tx frame sync edge starts channels
// - Clock master: drive tx frame sync pulse
// - Slave modes: rx frame sync edge starts output
// - Clock master format 1: rx sync marks B2
// - Control channel shifts only while select low
// - Latched open-drain interrupt on loop status change
// - Pin A default: wake pull-down when powered down
// - Rx data on bit clock, tristate otherwise
// - Clock master: pin B is D tx window
// - Network modes: pin B D window each frame
// - Clock slave: pin B is recovered clock
// - Pin-role command reassigns alternate pins
// - x2 picks pin B, x1x0 picks pin A
// - Burst-clock command changes rx frame sync role
// - Clock master: E1 then F1 gives burst clocks, D input
// - D rx window high during D rx bits
`ifndef STDI_DEFS_SVH
`define STDI_DEFS_SVH

`define STDI_ADDR_CTRL      8'h00
`define STDI_ADDR_CMD       8'h04
`define STDI_ADDR_RXDATA    8'h08
`define STDI_ADDR_TXCAP     8'h0c
`define STDI_ADDR_STATUS    8'h10
`define STDI_ADDR_MASK      8'h14
`define STDI_ADDR_LINE      8'h18

`define STDI_CTRL_RST       4'h0
`define STDI_PINS_RST       4'h0
`define STDI_STAT_TXCAP     0
`define STDI_STAT_LOOP      1
`define STDI_STAT_CMD       2

`define STDI_CMD_PIN_ROLE_COMMAND_TAG 5'h1c
`define STDI_CMD_BURST      8'hf1
`define STDI_CMD_PIN_ROLE_COMMAND_SEL 3'h1

`define STDI_SLOT_B2_FIRST  5'h08
`define STDI_SLOT_B2_LAST   5'h0f
`define STDI_SLOT_D_FIRST   5'h10
`define STDI_SLOT_END       5'h12
`define STDI_FRAME_BITS     32
`define STDI_SYS_CLK_KHZ    250000
`define STDI_TEM_BCLK_KHZ   256
`define STDI_TEM_HALF_CYC   (`STDI_SYS_CLK_KHZ / (2 * `STDI_TEM_BCLK_KHZ))

`define STDI_RESP_OKAY      2'h0
`define STDI_RESP_SLVERR    2'h2

`endif

// File: src/stdi_pkg.sv
// Purpose: Types shared by the S/T digital system interface block.
// Assumes: Nothing beyond the defs header.
// Notes:   Field order of the structs is the register bit order.
package stdi_pkg;

	typedef enum logic [1:0] {
		STDI_TEM = 2'h0,
		STDI_TES = 2'h1,
		STDI_NTA = 2'h2,
		STDI_NTF = 2'h3
	} stdi_mode_t;

	typedef struct packed {
		logic       powered;
		logic       fmt1;
		stdi_mode_t mode;
	} stdi_ctrl_t;

	typedef struct packed {
		logic       burst;
		logic       b_clk;
		logic [1:0] a_sel;
	} stdi_pins_t;

endpackage

// File: src/stdi_sync.sv
// Purpose: Two flip-flop synchroniser for pins from outside the clock.
// Assumes: Each bit is an independent level.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/100ps
module stdi_sync #(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	input  wire logic         ref_clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			meta_q <= RST_VAL;
			sync_o <= RST_VAL;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule

// File: src/stdi_top.sv
// Purpose: Digital system interface of an S/T line transceiver.
// Assumes: All pins and the bit clock are sampled by ref_clk_i.
// Notes:   Open-drain and tristate pins are value plus active-low enable.
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/100ps
`include "stdi_defs.svh"
module stdi_top #(
	parameter int FRAME_BITS = `STDI_FRAME_BITS,
	parameter int HALF_CYC   = `STDI_TEM_HALF_CYC
) (
	input  wire logic        ref_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	output logic             irq_o,
	input  wire logic        bclk_i,
	output logic             bclk_o,
	output logic             bclk_oe_n_o,
	input  wire logic        tx_frame_sync_i,
	output logic             tx_frame_sync_o,
	output logic             tx_frame_sync_oe_n_o,
	input  wire logic        rx_frame_sync_i,
	output logic             rx_frame_sync_o,
	output logic             rx_frame_sync_oe_n_o,
	input  wire logic        tx_serial_in_i,
	output logic             rx_serial_out_o,
	output logic             rx_serial_out_oe_n_o,
	input  wire logic        cs_n_i,
	input  wire logic        ctl_clk_i,
	input  wire logic        control_serial_in_i,
	output logic             ctl_serial_out_o,
	output logic             ctl_serial_out_oe_n_o,
	output logic             status_irq_n_o,
	output logic             status_irq_n_oe_n_o,
	output logic             alt_pin_a_o,
	output logic             alt_pin_a_oe_n_o,
	output logic             alt_pin_b_o,
	input  wire logic        line_signal_i,
	input  wire logic [3:0]  loop_status_i
);
	import stdi_pkg::*;

	localparam int FW = $clog2(FRAME_BITS);

	function automatic logic in_d_slot(input logic [4:0] c);
		in_d_slot = (c >= `STDI_SLOT_D_FIRST) && (c < `STDI_SLOT_END);
	endfunction

	function automatic stdi_pins_t pin_default(input stdi_mode_t m);
		pin_default = '{burst: 1'b0, b_clk: (m == STDI_TES), a_sel: 2'h0};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		merge = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				merge[8*i +: 8] = n[8*i +: 8];
			end
		end
	endfunction

	// Pin synchronisers; select idles high so reset does not look selected
	logic [7:0] pin_s;
	logic [7:0] prev_q;
	stdi_sync #(.W(8), .RST_VAL(8'h08)) u_sync (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.async_i   ({bclk_i, tx_frame_sync_i, rx_frame_sync_i,
		              tx_serial_in_i, cs_n_i, ctl_clk_i,
		              control_serial_in_i, line_signal_i}),
		.sync_o    (pin_s)
	);
	wire logic bclk_s   = pin_s[7];
	wire logic txfs_s   = pin_s[6];
	wire logic rxfs_s   = pin_s[5];
	wire logic txin_s   = pin_s[4];
	wire logic cs_s     = pin_s[3];
	wire logic cclk_s   = pin_s[2];
	wire logic ci_s     = pin_s[1];
	wire logic line_s   = pin_s[0];

	stdi_ctrl_t  ctrl_q;
	stdi_pins_t  pins_q;
	logic [17:0] rxdata_q, txcap_q, tx_sh_q, rx_sh_q;
	logic [2:0]  status_q, mask_q;
	logic [4:0]  tx_cnt_q, rx_cnt_q;
	logic [FW-1:0] fr_q;
	logic [15:0] div_q;
	logic        bclk_int_q, bsel_p_q, int_q;
	logic [3:0]  loop_q;

	wire logic terminal_clock_master_mode      = (ctrl_q.mode == STDI_TEM);
	wire logic burst_on = terminal_clock_master_mode & pins_q.burst;

	// Master-mode bit clock; also stands in for the recovered clock, so
	// its phase follows ref_clk_i rather than the line.
	wire logic div_end  = (div_q == 16'(HALF_CYC - 1));
	wire logic bclk_sel = terminal_clock_master_mode ? bclk_int_q : bclk_s;
	wire logic rise     = bclk_sel & ~bsel_p_q;
	wire logic fr_wrap  = (fr_q == FW'(FRAME_BITS - 1));
	wire logic tx_fs_ev = terminal_clock_master_mode ? (rise & fr_wrap) : (txfs_s & ~prev_q[6]);
	wire logic rx_fs_ev = terminal_clock_master_mode ? (rise & fr_wrap) : (rxfs_s & ~prev_q[5]);
	wire logic tx_act   = tx_cnt_q < `STDI_SLOT_END;
	wire logic rx_act   = rx_cnt_q < `STDI_SLOT_END;
	wire logic d_tx_win = in_d_slot(tx_cnt_q);
	wire logic d_rx_win = in_d_slot(rx_cnt_q);
	wire logic rx_b2    = (rx_cnt_q >= `STDI_SLOT_B2_FIRST) &&
	                      (rx_cnt_q <= `STDI_SLOT_B2_LAST);
	// Burst mode takes the D bits from the rx frame sync pin
	wire logic tx_bit   = (burst_on & d_tx_win) ? rxfs_s : txin_s;
	wire logic tx_done  = rise & (tx_cnt_q == `STDI_SLOT_END - 5'h01);

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			div_q      <= 16'h0000;
			bclk_int_q <= 1'b0;
			bsel_p_q   <= 1'b0;
			prev_q     <= 8'h08;
			fr_q       <= '0;
		end else begin
			div_q      <= div_end ? 16'h0000 : div_q + 16'h0001;
			bclk_int_q <= bclk_int_q ^ div_end;
			bsel_p_q   <= bclk_sel;
			prev_q     <= pin_s;
			if (rise) begin
				fr_q <= fr_wrap ? '0 : fr_q + FW'(1);
			end
		end
	end

	// Transmit slot counter and capture of B1, B2, D from the far side
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			tx_cnt_q <= `STDI_SLOT_END;
			tx_sh_q  <= 18'h00000;
			txcap_q  <= 18'h00000;
		end else if (tx_fs_ev) begin
			tx_cnt_q <= 5'h00;
		end else if (rise & tx_act) begin
			tx_cnt_q <= tx_cnt_q + 5'h01;
			tx_sh_q  <= {tx_sh_q[16:0], tx_bit};
			if (tx_done) begin
				txcap_q <= {tx_sh_q[16:0], tx_bit};
			end
		end
	end

	// Receive shifter; bit 17 appears at the frame sync, next ones on rises
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rx_cnt_q <= `STDI_SLOT_END;
			rx_sh_q  <= 18'h00000;
		end else if (rx_fs_ev) begin
			rx_cnt_q <= 5'h00;
			rx_sh_q  <= rxdata_q;
		end else if (rise & rx_act) begin
			rx_cnt_q <= rx_cnt_q + 5'h01;
			rx_sh_q  <= {rx_sh_q[16:0], 1'b0};
		end
	end

	assign rx_serial_out_o      = rx_sh_q[17];
	assign rx_serial_out_oe_n_o = ~rx_act;
	assign bclk_o               = bclk_int_q;
	assign bclk_oe_n_o          = ~terminal_clock_master_mode;
	assign tx_frame_sync_o      = terminal_clock_master_mode & (fr_q == '0);
	assign tx_frame_sync_oe_n_o = ~terminal_clock_master_mode;
	assign rx_frame_sync_o      = ctrl_q.fmt1 ? rx_b2 : (fr_q == '0);
	assign rx_frame_sync_oe_n_o = ~(terminal_clock_master_mode & ~pins_q.burst);

	// Alternate pins
	wire logic sclk      = bclk_int_q;
	wire logic wake_pull = ~ctrl_q.powered & line_s;
	wire logic a_cmos    = burst_on | (pins_q.a_sel != 2'h0);
	wire logic a_func    = (pins_q.a_sel == 2'h1) ? d_rx_win :
	                       (pins_q.a_sel == 2'h2) ? sclk : d_tx_win;
	assign alt_pin_a_o      = burst_on ? (bclk_sel & d_rx_win) :
	                          (a_cmos & a_func);
	assign alt_pin_a_oe_n_o = ~(a_cmos | wake_pull);
	assign alt_pin_b_o      = burst_on ? (bclk_sel & d_tx_win) :
	                          pins_q.b_clk ? sclk : d_tx_win;

	// Control channel: serial command in, status byte out
	logic [7:0] ctl_sh_q, ctl_out_q;
	logic [3:0] ctl_cnt_q;
	wire logic cclk_rise = cclk_s & ~prev_q[2];
	wire logic cs_end    = cs_s & ~prev_q[3];
	wire logic ser_cmd   = cs_end & (ctl_cnt_q == 4'h8);
	wire logic stat_read = ser_cmd; // full byte clocked out reads the status

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			ctl_sh_q  <= 8'h00;
			ctl_out_q <= 8'h00;
			ctl_cnt_q <= 4'h0;
		end else if (cs_s) begin
			ctl_cnt_q <= 4'h0;
			ctl_out_q <= {int_q, 3'h0, loop_status_i};
		end else if (cclk_rise & (ctl_cnt_q != 4'h8)) begin
			ctl_sh_q  <= {ctl_sh_q[6:0], ci_s};
			ctl_out_q <= {ctl_out_q[6:0], 1'b0};
			ctl_cnt_q <= ctl_cnt_q + 4'h1;
		end
	end
	assign ctl_serial_out_o      = ctl_out_q[7];
	assign ctl_serial_out_oe_n_o = cs_s;

	// AXI4-Lite slave; one write and one read in flight
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        aw_full_q, w_full_q;
	wire logic wr_fire = aw_full_q & w_full_q & ~s_axi_bvalid_o;
	wire logic wr_ctrl = wr_fire & (aw_addr_q == `STDI_ADDR_CTRL) & w_strb_q[0];
	wire logic wr_cmd  = wr_fire & (aw_addr_q == `STDI_ADDR_CMD) & w_strb_q[0];
	wire logic [31:0] wd_rx = merge({14'h0000, rxdata_q}, w_data_q, w_strb_q);
	wire logic wr_hit  = (aw_addr_q <= `STDI_ADDR_LINE) & (aw_addr_q[1:0] == 2'h0);
	wire logic rd_hit  = (s_axi_araddr_i <= `STDI_ADDR_LINE) &
	                     (s_axi_araddr_i[1:0] == 2'h0);
	wire logic [31:0] rd_word =
		(s_axi_araddr_i == `STDI_ADDR_CTRL)   ? {28'h0, ctrl_q} :
		(s_axi_araddr_i == `STDI_ADDR_CMD)    ? {28'h0, pins_q} :
		(s_axi_araddr_i == `STDI_ADDR_RXDATA) ? {14'h0, rxdata_q} :
		(s_axi_araddr_i == `STDI_ADDR_TXCAP)  ? {14'h0, txcap_q} :
		(s_axi_araddr_i == `STDI_ADDR_STATUS) ? {29'h0, status_q} :
		(s_axi_araddr_i == `STDI_ADDR_MASK)   ? {29'h0, mask_q} :
		(s_axi_araddr_i == `STDI_ADDR_LINE)   ?
			{26'h0, int_q, line_s, loop_status_i} : 32'h00000000;

	assign s_axi_awready_o = ~aw_full_q & ~s_axi_bvalid_o;
	assign s_axi_wready_o  = ~w_full_q & ~s_axi_bvalid_o;
	assign s_axi_arready_o = ~s_axi_rvalid_o;

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			aw_full_q      <= 1'b0;
			w_full_q       <= 1'b0;
			aw_addr_q      <= 8'h00;
			w_data_q       <= 32'h00000000;
			w_strb_q       <= 4'h0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= `STDI_RESP_OKAY;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rresp_o  <= `STDI_RESP_OKAY;
			s_axi_rdata_o  <= 32'h00000000;
		end else begin
			if (s_axi_awvalid_i & s_axi_awready_o) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i & s_axi_wready_o) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata_i;
				w_strb_q <= s_axi_wstrb_i;
			end
			if (wr_fire) begin
				aw_full_q      <= 1'b0;
				w_full_q       <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wr_hit ? `STDI_RESP_OKAY : `STDI_RESP_SLVERR;
			end else if (s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
			if (s_axi_arvalid_i & s_axi_arready_o) begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o  <= rd_word;
				s_axi_rresp_o  <= rd_hit ? `STDI_RESP_OKAY : `STDI_RESP_SLVERR;
			end else if (s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
			end
		end
	end

	// Commands from the serial channel win over a bus command write in the same cycle; a CTRL write wins over them
	wire logic [7:0] cmd_val   = ser_cmd ? ctl_sh_q : w_data_q[7:0];
	wire logic       cmd_ev    = ser_cmd | wr_cmd;
	wire logic       is_pin_role_command = cmd_val[7:3] == `STDI_CMD_PIN_ROLE_COMMAND_TAG;
	wire logic       is_burst  = cmd_val == `STDI_CMD_BURST;
	wire logic       e1_set    = ~pins_q.burst & ~pins_q.b_clk &
	                             ({pins_q.b_clk, pins_q.a_sel} == `STDI_CMD_PIN_ROLE_COMMAND_SEL);
	wire logic       loop_chg  = loop_q != loop_status_i;
	wire logic [2:0] stat_ev   = {cmd_ev, loop_chg, tx_done};
	wire logic [2:0] w1c       = (wr_fire & (aw_addr_q == `STDI_ADDR_STATUS) &
	                             w_strb_q[0]) ? w_data_q[2:0] : 3'h0;

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			ctrl_q   <= stdi_ctrl_t'(`STDI_CTRL_RST);
			pins_q   <= stdi_pins_t'(`STDI_PINS_RST);
			rxdata_q <= 18'h00000;
			mask_q   <= 3'h0;
			status_q <= 3'h0;
			int_q    <= 1'b0;
			loop_q   <= 4'h0;
		end else begin
			loop_q   <= loop_status_i;
			status_q <= stat_ev | (status_q & ~w1c);
			int_q    <= loop_chg | (int_q & ~stat_read);
			if (wr_fire & (aw_addr_q == `STDI_ADDR_RXDATA)) begin
				rxdata_q <= wd_rx[17:0];
			end
			if (wr_fire & (aw_addr_q == `STDI_ADDR_MASK) & w_strb_q[0]) begin
				mask_q <= w_data_q[2:0];
			end
			if (wr_ctrl) begin
				ctrl_q <= stdi_ctrl_t'(w_data_q[3:0]);
				pins_q <= pin_default(stdi_mode_t'(w_data_q[1:0]));
			end else if (cmd_ev & is_pin_role_command) begin
				pins_q <= '{burst: 1'b0, b_clk: cmd_val[2],
				            a_sel: cmd_val[1:0]};
			end else if (cmd_ev & is_burst & terminal_clock_master_mode & e1_set) begin
				pins_q.burst <= 1'b1;
			end
		end
	end

	assign irq_o               = |(status_q & mask_q);
	assign status_irq_n_o      = 1'b0;
	assign status_irq_n_oe_n_o = ~int_q;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence frame_start_s;
		tx_fs_ev ##1 (tx_cnt_q == 5'h00);
	endsequence
	sequence pin_e1_s;
		terminal_clock_master_mode & e1_set & cmd_ev & is_burst & ~wr_ctrl;
	endsequence

	tx_frame_start_a: assert property (
		~terminal_clock_master_mode & txfs_s & ~prev_q[6] |-> frame_start_s)
		else $error("tx slot count not restarted by frame sync");
	master_fs_out_a: assert property (
		terminal_clock_master_mode & rise & fr_wrap & ~wr_ctrl |=>
		tx_frame_sync_o & ~tx_frame_sync_oe_n_o)
		else $error("master tx frame sync pulse missing");
	rx_frame_start_a: assert property (
		rx_fs_ev |=> ~rx_serial_out_oe_n_o && rx_cnt_q == 5'h00)
		else $error("rx output not started at frame sync");
	b2_sync_pulse_a: assert property (
		terminal_clock_master_mode & ctrl_q.fmt1 & $rose(rx_frame_sync_o) |-> rx_cnt_q == 5'h08)
		else $error("rx frame sync pulse not at B2 slot");
	select_gate_a: assert property (
		cs_s |=> $stable(ctl_sh_q))
		else $error("control shifted while deselected");
	irq_latch_a: assert property (
		loop_chg |=> ~status_irq_n_oe_n_o [*1] ##0 int_q)
		else $error("interrupt not pulled on status change");
	irq_release_a: assert property (
		int_q & ~stat_read & ~loop_chg |=> int_q ##0 ~status_irq_n_oe_n_o)
		else $error("interrupt released before status read");
	wake_pull_a: assert property (
		~burst_on & (pins_q.a_sel == 2'h0) & wake_pull |->
		~alt_pin_a_oe_n_o & ~alt_pin_a_o)
		else $error("wake output not pulled low");
	pin_role_command_apply_a: assert property (
		cmd_ev & is_pin_role_command & ~wr_ctrl |=>
		pins_q.a_sel == $past(cmd_val[1:0]) && pins_q.b_clk == $past(cmd_val[2]))
		else $error("pin-role command not applied");
	burst_roles_a: assert property (
		pin_e1_s |=> burst_on ##0 rx_frame_sync_oe_n_o)
		else $error("burst clock roles not taken");
endmodule

// File: sim/stdi_far_model.sv
// Purpose: Far-side controller model: bit clock, frame syncs, tx data.
// Assumes: Bit clock period 48 ns, made only inside frames.
// Notes:   Released data line shows the inverse of its last bit.
`timescale 1ns/100ps
module stdi_far_model (
	input  wire logic ref_clk_i,
	input  wire logic rx_data_i,
	input  wire logic rx_oe_n_i,
	input  wire logic pin_b_i,
	output logic      bclk_o,
	output logic      tx_fs_o,
	output logic      rx_fs_o,
	output logic      tx_data_o
);
	initial begin
		bclk_o = 1'b0;
		tx_fs_o = 1'b0;
		rx_fs_o = 1'b0;
		tx_data_o = 1'b0;
	end

	// Offset 1 ns from the ref edge so no sample races a change
	task automatic frame(input logic [17:0] tx, output logic [17:0] rx,
		output logic [17:0] pb);
		int i;
		@(posedge ref_clk_i);
		#1;
		tx_fs_o = 1'b1;
		rx_fs_o = 1'b1;
		#24;
		tx_fs_o = 1'b0;
		rx_fs_o = 1'b0;
		for (i = 17; i >= 0; i--) begin
			tx_data_o = tx[i];
			#24;
			rx[i] = rx_oe_n_i ? 1'bx : rx_data_i;
			pb[i] = pin_b_i;
			bclk_o = 1'b1;
			#24;
			bclk_o = 1'b0;
		end
		tx_data_o = ~tx[0];
	endtask
endmodule

// File: sim/tb_top.sv
// Purpose: Self-checking bench for the system interface block.
// Assumes: Shortened bit clock divider to keep master frames brief.
// Notes:   Expected widths follow from HC and FB below.
`timescale 1ns/100ps
`include "stdi_defs.svh"
module tb_top;
	import stdi_pkg::*;
	localparam int HC = 3;
	localparam int FB = 32;
	localparam int BP = 2 * HC;
	logic        ref_clk_i, sys_rst_i, s_axi_awvalid_i, s_axi_awready_o;
	logic        s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
	logic        s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
	logic        s_axi_rvalid_o, s_axi_rready_i, irq_o, bclk_i, bclk_o;
	logic        bclk_oe_n_o, tx_frame_sync_i, tx_frame_sync_o;
	logic        tx_frame_sync_oe_n_o, rx_frame_sync_i, rx_frame_sync_o;
	logic        rx_frame_sync_oe_n_o, tx_serial_in_i, rx_serial_out_o;
	logic        rx_serial_out_oe_n_o, cs_n_i, ctl_clk_i;
	logic        control_serial_in_i, ctl_serial_out_o;
	logic        ctl_serial_out_oe_n_o, status_irq_n_o;
	logic        status_irq_n_oe_n_o, alt_pin_a_o, alt_pin_a_oe_n_o;
	logic        alt_pin_b_o, line_signal_i;
	logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd_q;
	logic [3:0]  s_axi_wstrb_i, loop_status_i;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, resp_q;
	logic [17:0] rx_q, pb_q;
	int          n_fail, num_checks;

	stdi_top #(.FRAME_BITS(FB), .HALF_CYC(HC)) uut (.*);

	stdi_far_model far (
		.ref_clk_i(ref_clk_i),
		.rx_data_i(rx_serial_out_o),
		.rx_oe_n_i(rx_serial_out_oe_n_o),
		.pin_b_i  (alt_pin_b_o),
		.bclk_o   (bclk_i),
		.tx_fs_o  (tx_frame_sync_i),
		.rx_fs_o  (rx_frame_sync_i),
		.tx_data_o(tx_serial_in_i)
	);

	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	task automatic conclude;
		if (n_fail == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic tmo(input string nm);
		n_fail++;
		$display("MISMATCH %s exp answer got timeout", nm);
		conclude();
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge ref_clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge ref_clk_i);
			if (!ad && s_axi_awready_o) begin
				ad = 1'b1;
				s_axi_awvalid_i <= 1'b0;
			end
			if (!wd && s_axi_wready_o) begin
				wd = 1'b1;
				s_axi_wvalid_i <= 1'b0;
			end
			if (s_axi_bvalid_o) begin
				resp_q = s_axi_bresp_o;
				s_axi_bready_i <= 1'b0;
				return;
			end
		end
		tmo("axi write");
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		int i;
		logic ad;
		ad = 1'b0;
		@(posedge ref_clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge ref_clk_i);
			if (!ad && s_axi_arready_o) begin
				ad = 1'b1;
				s_axi_arvalid_i <= 1'b0;
			end
			if (s_axi_rvalid_o) begin
				d = s_axi_rdata_o;
				resp_q = s_axi_rresp_o;
				s_axi_rready_i <= 1'b0;
				return;
			end
		end
		tmo("axi read");
	endtask

	task automatic ctl_byte(input logic [7:0] b, input logic sel,
		output logic [7:0] so);
		int i;
		cs_n_i <= ~sel;
		cyc(6);
		for (i = 7; i >= 0; i--) begin
			control_serial_in_i <= b[i];
			cyc(4);
			so[i] = ctl_serial_out_o;
			ctl_clk_i <= 1'b1;
			cyc(4);
			ctl_clk_i <= 1'b0;
		end
		cyc(4);
		cs_n_i <= 1'b1;
		cyc(6);
	endtask

	task automatic t_reset;
		chk("irq", 0, irq_o);
		chk("rx oe_n", 1, rx_serial_out_oe_n_o);
		chk("int oe_n", 1, status_irq_n_oe_n_o);
		rd(`STDI_ADDR_CTRL, rd_q);
		chk("ctrl", 0, rd_q);
		rd(8'h1c, rd_q);
		chk("bad rd", `STDI_RESP_SLVERR, resp_q);
		wr(8'h1c, 32'hf);
		chk("bad wr", `STDI_RESP_SLVERR, resp_q);
	endtask

	task automatic t_pins;
		int x;
		for (x = 0; x < 8; x++) begin
			wr(`STDI_ADDR_CMD, 32'he0 | 32'(x));
			rd(`STDI_ADDR_CMD, rd_q);
			chk("roles", 32'(x), rd_q);
			chk("pin a oe_n", x[1:0] == 2'h0, alt_pin_a_oe_n_o);
		end
	endtask

	task automatic t_wake;
		wr(`STDI_ADDR_CTRL, 32'h0);
		line_signal_i <= 1'b1;
		cyc(5);
		chk("wake oe_n", 0, alt_pin_a_oe_n_o);
		chk("wake lvl", 0, alt_pin_a_o);
		wr(`STDI_ADDR_CTRL, 32'h8);
		cyc(2);
		chk("awake oe_n", 1, alt_pin_a_oe_n_o);
		line_signal_i <= 1'b0;
	endtask

	task automatic t_frame;
		wr(`STDI_ADDR_CTRL, {28'h0, 2'b10, STDI_NTA});
		wr(`STDI_ADDR_RXDATA, 32'h2d38b);
		// Master frames since reset may have left flags set
		wr(`STDI_ADDR_STATUS, 32'h7);
		wr(`STDI_ADDR_MASK, 32'h1);
		chk("irq idle", 0, irq_o);
		far.frame(18'h1c5a7, rx_q, pb_q);
		cyc(6);
		chk("rx bits", 32'h2d38b, rx_q);
		chk("d win", 32'h3, pb_q);
		chk("rx done", 1, rx_serial_out_oe_n_o);
		rd(`STDI_ADDR_TXCAP, rd_q);
		chk("tx bits", 32'h1c5a7, rd_q);
		chk("irq set", 1, irq_o);
		wr(`STDI_ADDR_STATUS, 32'h1);
		cyc(1);
		chk("irq clr", 0, irq_o);
		wr(`STDI_ADDR_MASK, 32'h0);
	endtask

	task automatic t_ctl;
		logic [7:0] so;
		loop_status_i <= 4'h5;
		cyc(3);
		chk("int pin", 0, status_irq_n_oe_n_o);
		chk("int lvl", 0, status_irq_n_o);
		chk("irq mask", 0, irq_o);
		ctl_byte(8'he1, 1'b0, so);
		chk("no sel int", 0, status_irq_n_oe_n_o);
		chk("no sel out", 1, ctl_serial_out_oe_n_o);
		rd(`STDI_ADDR_CMD, rd_q);
		chk("no sel cmd", 0, rd_q);
		ctl_byte(8'he1, 1'b1, so);
		chk("status", 8'h85, so);
		chk("int rel", 1, status_irq_n_oe_n_o);
		rd(`STDI_ADDR_CMD, rd_q);
		chk("ser cmd", 1, rd_q);
		rd(`STDI_ADDR_STATUS, rd_q);
		chk("sticky", 32'h6, rd_q);
	endtask

	task automatic t_master;
		int i, nt, nr, nb;
		nt = 0;
		nr = 0;
		nb = 0;
		wr(`STDI_ADDR_CTRL, 32'hc);
		cyc(2);
		chk("bclk drv", 0, bclk_oe_n_o);
		chk("fs drv", 0, tx_frame_sync_oe_n_o);
		chk("rfs drv", 0, rx_frame_sync_oe_n_o);
		i = 0;
		while (tx_frame_sync_o !== 1'b1) begin
			if (++i > 400) tmo("frame sync");
			cyc(1);
		end
		for (i = 0; i < FB * BP; i++) begin
			nt += tx_frame_sync_o;
			nr += rx_frame_sync_o;
			nb += alt_pin_b_o;
			cyc(1);
		end
		chk("tx fs width", BP, nt);
		chk("rx fs width", 8 * BP, nr);
		chk("d tx width", 2 * BP, nb);
	endtask

	task automatic t_burst;
		int i, na, nb;
		na = 0;
		nb = 0;
		wr(`STDI_ADDR_CMD, 32'he1);
		wr(`STDI_ADDR_CMD, 32'hf1);
		rd(`STDI_ADDR_CMD, rd_q);
		chk("burst", 32'h9, rd_q);
		chk("rfs in", 1, rx_frame_sync_oe_n_o);
		chk("pin a drv", 0, alt_pin_a_oe_n_o);
		// One whole frame: each burst is the high halves of two D bits
		for (i = 0; i < FB * BP; i++) begin
			na += alt_pin_a_o;
			nb += alt_pin_b_o;
			cyc(1);
		end
		chk("rx burst", 2 * HC, na);
		chk("tx burst", 2 * HC, nb);
	endtask

	task automatic t_slave;
		int i, nb;
		nb = 0;
		wr(`STDI_ADDR_CTRL, {28'h0, 2'b10, STDI_TES});
		rd(`STDI_ADDR_CMD, rd_q);
		chk("tes roles", 32'h4, rd_q);
		for (i = 0; i < BP; i++) begin
			nb += alt_pin_b_o;
			cyc(1);
		end
		chk("tes clock", HC, nb);
	endtask

	initial begin
		n_fail = 0;
		num_checks = 0;
		sys_rst_i = 1'b1;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 3'h0;
		{s_axi_arvalid_i, s_axi_rready_i} = 2'h0;
		s_axi_awaddr_i = 8'h0;
		s_axi_araddr_i = 8'h0;
		s_axi_wdata_i = 32'h0;
		s_axi_wstrb_i = 4'hf;
		cs_n_i = 1'b1;
		ctl_clk_i = 1'b0;
		control_serial_in_i = 1'b0;
		line_signal_i = 1'b0;
		loop_status_i = 4'h0;
		repeat (12) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		t_reset();
		t_pins();
		t_wake();
		t_frame();
		t_ctl();
		t_master();
		t_burst();
		t_slave();
		conclude();
	end
endmodule
